// *** hdl/cs_freeze_pkg.sv ***
// Constants for the carrier sense and level freeze block
// Assumes a single 200 MHz clock; filter samples and converter ticks arrive as strobes
package cs_freeze_pkg;
	// Register indices on the plain register port
	localparam logic [3:0] ADDR_CFG     = 4'h0;
	localparam logic [3:0] ADDR_STATUS  = 4'h1;
	localparam logic [3:0] ADDR_IRQ_ST  = 4'h2;
	localparam logic [3:0] ADDR_IRQ_EN  = 4'h3;
	localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;
	localparam logic [3:0] ADDR_FILT    = 4'h5;
	// Reset values
	localparam logic [7:0] CFG_RESET    = 8'h65;
	localparam logic [7:0] FILT_RESET   = 8'h01;
	// Field positions of gain_control_config_one
	localparam int CS_SET_LSB   = 6;
	localparam int CS_REL_BIT   = 5;
	localparam int HOLD_SEL_LSB = 2;
	localparam int EXTRA_LSB    = 0;
	// Field positions of the filter setup register
	localparam int DECIMATION_DIVISOR_SELECT_LSB  = 0;
	localparam int AVG_SEL_LSB  = 4;
	// Hold code that freezes forever
	localparam logic [2:0] HOLD_FOREVER = 3'h7;
	// Base rate divider: 307.2 kHz out of 200 MHz
	localparam int REF_CLK_HZ   = 200_000_000;
	localparam int BASE_RATE_HZ = 307_200;
	localparam int BASE_DIV     = REF_CLK_HZ / BASE_RATE_HZ;
	// Interrupt event bit positions
	localparam int EV_CS_RISE   = 0;
	localparam int EV_CS_FALL   = 1;
	localparam int EV_FRZ_DONE  = 2;
	localparam int NUM_EV       = 3;
	typedef enum logic [1:0] {
		FRZ_IDLE,
		FRZ_FILT,
		FRZ_CONV,
		FRZ_HOLD
	} frz_state_t;
endpackage

// *** hdl/cs_run_counter.sv ***
// Consecutive-sample run counter for one side of the threshold
// Assumes sample strobe and comparison are synchronous to the clock
`timescale 1ns/1ps
module cs_run_counter #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Samples
	input  wire logic         sample,
	input  wire logic         hit,
	input  wire logic [W-1:0] need,
	// Result
	output logic              reached
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (sample) begin
			if (!hit) begin
				cnt_d = '0;
			end else if (cnt_q < need) begin
				cnt_d = cnt_q + W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign reached = sample && hit && (cnt_q + W'(1) >= need);
endmodule

// *** hdl/cs_freeze.sv ***
// Carrier sense qualification and gain-level freeze timer
// Assumes magnitude samples and converter ticks are synchronous strobes
`timescale 1ns/1ps
module cs_freeze #(
	parameter int MAG_W = 8
) (
	// Clock and reset
	input  wire logic             REF_CLK,
	input  wire logic             RST_N,
	// Register port
	input  wire logic [3:0]       ADDR,
	input  wire logic [7:0]       WDATA,
	input  wire logic             WR,
	input  wire logic             RD,
	output logic      [7:0]       RDATA,
	// Receive path
	input  wire logic             FILT_VALID,
	input  wire logic [MAG_W-1:0] MAGNITUDE,
	input  wire logic [MAG_W-1:0] THRESHOLD,
	input  wire logic             ADC_TICK,
	// Freeze triggers
	input  wire logic             FREQ_SWITCH,
	input  wire logic             LOCK_LOST,
	input  wire logic             RX_POWER_UP,
	// Outputs
	output logic                  LOCK_PIN,
	output logic                  CARRIER_SENSE,
	output logic                  FREEZE,
	output logic                  FILTER_CLK_TICK,
	output logic                  IRQ
);
	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0]                   cfg_q, cfg_d;
	logic [7:0]                   filt_q, filt_d;
	logic [cs_freeze_pkg::NUM_EV-1:0] ist_q, ist_d, ien_q, ien_d;
	logic [7:0]                   rdata_q, rdata_d;
	logic                         irq_q, irq_d;
	logic [cs_freeze_pkg::NUM_EV-1:0] ev;

	logic [1:0] cs_set;
	logic       cs_rel;
	logic [2:0] hold_sel;
	logic [1:0] extra_sel;
	logic [2:0] decimation_divisor_select;
	logic [1:0] avg_sel;
	assign cs_set    = cfg_q[cs_freeze_pkg::CS_SET_LSB +: 2];
	assign cs_rel    = cfg_q[cs_freeze_pkg::CS_REL_BIT];
	assign hold_sel  = cfg_q[cs_freeze_pkg::HOLD_SEL_LSB +: 3];
	assign extra_sel = cfg_q[cs_freeze_pkg::EXTRA_LSB +: 2];
	assign decimation_divisor_select   = filt_q[cs_freeze_pkg::DECIMATION_DIVISOR_SELECT_LSB +: 3];
	assign avg_sel   = filt_q[cs_freeze_pkg::AVG_SEL_LSB +: 2];

	////////////////////////////////////////////////////////////////////////
	// Filter clock: base 307.2 kHz strobe divided by the decimation divisor
	logic [15:0] base_q, base_d;
	logic [2:0]  dec_q, dec_d;
	logic        ftick_q, ftick_d;
	logic        base_tick;

	always_comb begin
		base_tick = (base_q == 16'(cs_freeze_pkg::BASE_DIV - 1));
		base_d    = base_tick ? 16'h0000 : base_q + 16'h0001;
		dec_d     = dec_q;
		ftick_d   = 1'b0;
		if (base_tick) begin
			if (dec_q >= decimation_divisor_select) begin
				dec_d   = 3'h0;
				ftick_d = 1'b1;
			end else begin
				dec_d = dec_q + 3'h1;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			base_q  <= 16'h0000;
			dec_q   <= 3'h0;
			ftick_q <= 1'b0;
		end else begin
			base_q  <= base_d;
			dec_q   <= dec_d;
			ftick_q <= ftick_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Magnitude averaging; power-of-two window so a shift divides
	logic [MAG_W+3:0] acc_q, acc_d;
	logic [3:0]       nav_q, nav_d;
	logic [MAG_W-1:0] avg_q, avg_d;
	logic             avg_vld_q, avg_vld_d;
	logic [3:0]       nav_last;

	always_comb begin
		nav_last  = 4'((2 << avg_sel) - 1);
		acc_d     = acc_q;
		nav_d     = nav_q;
		avg_d     = avg_q;
		avg_vld_d = 1'b0;
		if (FILT_VALID) begin
			if (nav_q >= nav_last) begin
				avg_d     = MAG_W'((acc_q + (MAG_W+4)'(MAGNITUDE)) >> ({1'b0, avg_sel} + 3'd1));
				avg_vld_d = 1'b1;
				acc_d     = '0;
				nav_d     = 4'h0;
			end else begin
				acc_d = acc_q + (MAG_W+4)'(MAGNITUDE);
				nav_d = nav_q + 4'h1;
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			acc_q     <= '0;
			nav_q     <= 4'h0;
			avg_q     <= '0;
			avg_vld_q <= 1'b0;
		end else begin
			acc_q     <= acc_d;
			nav_q     <= nav_d;
			avg_q     <= avg_d;
			avg_vld_q <= avg_vld_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Carrier sense qualification
	logic       above;
	logic       set_hit, clr_hit;
	logic       cs_q, cs_d;
	assign above = (avg_q >= THRESHOLD);

	cs_run_counter #(.W(3)) u_set_run (
		.clk     (REF_CLK),
		.rst_n   (RST_N),
		.sample  (avg_vld_q),
		.hit     (above),
		.need    ({1'b0, cs_set} + 3'h1),
		.reached (set_hit)
	);

	cs_run_counter #(.W(3)) u_clr_run (
		.clk     (REF_CLK),
		.rst_n   (RST_N),
		.sample  (avg_vld_q),
		.hit     (!above),
		.need    ({2'b00, cs_rel} + 3'h1),
		.reached (clr_hit)
	);

	always_comb begin
		cs_d = cs_q;
		if (set_hit) begin
			cs_d = 1'b1;
		end else if (clr_hit) begin
			cs_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Freeze timer: filter-clock hold, then converter-clock hold
	cs_freeze_pkg::frz_state_t st_q, st_d;
	logic [7:0] fcnt_q, fcnt_d;
	logic [7:0] hold_len, extra_len;
	logic       trig;
	logic       frz_q, frz_d;
	logic       done;

	always_comb begin
		unique case (hold_sel)
			3'h0:    hold_len = 8'h10;
			3'h1:    hold_len = 8'h14;
			3'h2:    hold_len = 8'h18;
			3'h3:    hold_len = 8'h1c;
			3'h4:    hold_len = 8'h20;
			3'h5:    hold_len = 8'h28;
			default: hold_len = 8'h30;
		endcase
		extra_len = 8'(8'h10 << extra_sel);
		trig      = FREQ_SWITCH || LOCK_LOST || RX_POWER_UP;
		st_d      = st_q;
		fcnt_d    = fcnt_q;
		done      = 1'b0;
		unique case (st_q)
			cs_freeze_pkg::FRZ_IDLE: begin
				if (trig) begin
					st_d   = cs_freeze_pkg::FRZ_FILT;
					fcnt_d = 8'h00;
				end
			end
			cs_freeze_pkg::FRZ_FILT: begin
				if (trig) begin
					fcnt_d = 8'h00;
				end else if (ftick_q) begin
					if (fcnt_q + 8'h01 >= hold_len) begin
						st_d   = cs_freeze_pkg::FRZ_CONV;
						fcnt_d = 8'h00;
					end else begin
						fcnt_d = fcnt_q + 8'h01;
					end
				end
			end
			cs_freeze_pkg::FRZ_CONV: begin
				if (trig) begin
					st_d   = cs_freeze_pkg::FRZ_FILT;
					fcnt_d = 8'h00;
				end else if (ADC_TICK) begin
					if (fcnt_q + 8'h01 >= extra_len) begin
						st_d = cs_freeze_pkg::FRZ_IDLE;
						done = 1'b1;
					end else begin
						fcnt_d = fcnt_q + 8'h01;
					end
				end
			end
			cs_freeze_pkg::FRZ_HOLD: begin
				// A trigger in the cycle code 7 is left must not be lost
				if (trig) begin
					st_d   = cs_freeze_pkg::FRZ_FILT;
					fcnt_d = 8'h00;
				end else begin
					st_d = cs_freeze_pkg::FRZ_IDLE;
				end
			end
		endcase
		if (hold_sel == cs_freeze_pkg::HOLD_FOREVER) begin
			st_d   = cs_freeze_pkg::FRZ_HOLD;
			done   = 1'b0;
		end
		frz_d = (st_d != cs_freeze_pkg::FRZ_IDLE);
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q   <= cs_freeze_pkg::FRZ_IDLE;
			fcnt_q <= 8'h00;
			frz_q  <= 1'b0;
			cs_q   <= 1'b0;
		end else begin
			st_q   <= st_d;
			fcnt_q <= fcnt_d;
			frz_q  <= frz_d;
			cs_q   <= cs_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port and interrupts; a set wins over a clear in the same cycle
	always_comb begin
		ev = '0;
		ev[cs_freeze_pkg::EV_CS_RISE]  = cs_d && !cs_q;
		ev[cs_freeze_pkg::EV_CS_FALL]  = !cs_d && cs_q;
		ev[cs_freeze_pkg::EV_FRZ_DONE] = done;
		cfg_d   = cfg_q;
		filt_d  = filt_q;
		ien_d   = ien_q;
		ist_d   = ist_q;
		rdata_d = 8'h00;
		if (WR) begin
			unique case (ADDR)
				cs_freeze_pkg::ADDR_CFG:     cfg_d  = WDATA;
				cs_freeze_pkg::ADDR_FILT:    filt_d = WDATA;
				cs_freeze_pkg::ADDR_IRQ_EN:  ien_d  = WDATA[cs_freeze_pkg::NUM_EV-1:0];
				cs_freeze_pkg::ADDR_IRQ_CLR: ist_d  = ist_q & ~WDATA[cs_freeze_pkg::NUM_EV-1:0];
				default: ;
			endcase
		end
		ist_d = ist_d | ev;
		if (RD) begin
			unique case (ADDR)
				cs_freeze_pkg::ADDR_CFG:    rdata_d = cfg_q;
				cs_freeze_pkg::ADDR_FILT:   rdata_d = filt_q;
				cs_freeze_pkg::ADDR_STATUS: rdata_d = {6'h00, frz_q, cs_q};
				cs_freeze_pkg::ADDR_IRQ_ST: rdata_d = {5'h00, ist_q};
				cs_freeze_pkg::ADDR_IRQ_EN: rdata_d = {5'h00, ien_q};
				default:                    rdata_d = 8'h00;
			endcase
		end
		irq_d = |(ist_d & ien_d);
	end

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_q   <= cs_freeze_pkg::CFG_RESET;
			filt_q  <= cs_freeze_pkg::FILT_RESET;
			ien_q   <= '0;
			ist_q   <= '0;
			rdata_q <= 8'h00;
			irq_q   <= 1'b0;
		end else begin
			cfg_q   <= cfg_d;
			filt_q  <= filt_d;
			ien_q   <= ien_d;
			ist_q   <= ist_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
		end
	end

	assign RDATA           = rdata_q;
	assign LOCK_PIN        = cs_q;
	assign CARRIER_SENSE   = cs_q;
	assign FREEZE          = frz_q;
	assign FILTER_CLK_TICK = ftick_q;
	assign IRQ             = irq_q;
endmodule

// *** verification/cs_freeze_properties.sv ***
// Port checker for the carrier sense and freeze block
// Assumes it is bound into every instance of the block
`timescale 1ns/1ps
module cs_freeze_chk (
	// Clock and register port
	input wire logic       REF_CLK,
	input wire logic       RST_N,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	// Watched pins
	input wire logic       FILT_VALID,
	input wire logic       FREQ_SWITCH,
	input wire logic       LOCK_LOST,
	input wire logic       RX_POWER_UP,
	input wire logic       LOCK_PIN,
	input wire logic       CARRIER_SENSE,
	input wire logic       FREEZE,
	input wire logic       FILTER_CLK_TICK
);
	logic [7:0]  cfg_q, filt_q;
	logic [15:0] gap_q, fcnt_q;
	logic        trig, fwr;
	assign trig = FREQ_SWITCH | LOCK_LOST | RX_POWER_UP;
	assign fwr = WR && ADDR == cs_freeze_pkg::ADDR_FILT;
	function automatic int hold_len(input logic [2:0] c);
		return (c < 3'h5) ? 16 + 4 * int'(c) : 48 - 8 * int'(c == 3'h5);
	endfunction
	////////////////////////////////////////////////////////////////
	// Gap restarts on a divisor write: the first tick after it is out of phase
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cfg_q  <= cs_freeze_pkg::CFG_RESET;
			filt_q <= cs_freeze_pkg::FILT_RESET;
			gap_q  <= 16'h0000;
			fcnt_q <= 16'h0000;
		end else begin
			if (WR && ADDR == cs_freeze_pkg::ADDR_CFG) cfg_q <= WDATA;
			if (fwr) filt_q <= WDATA;
			gap_q <= fwr ? 16'h0000 : FILTER_CLK_TICK ? 16'h0001 : gap_q + {15'h0, |gap_q};
			fcnt_q <= trig ? 16'h0000 : fcnt_q + {15'h0, FILTER_CLK_TICK};
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////////////////////////////
	property p_lock; LOCK_PIN == CARRIER_SENSE; endproperty
	a_lock: assert property (p_lock) else $error("lock pin differs");
	property p_rise; $rose(CARRIER_SENSE) |-> $past(FILT_VALID, 2) || $past(FILT_VALID, 3); endproperty
	a_rise: assert property (p_rise) else $error("cs rose without sample");
	property p_fall; $fell(CARRIER_SENSE) |-> $past(FILT_VALID, 2) || $past(FILT_VALID, 3); endproperty
	a_fall: assert property (p_fall) else $error("cs fell without sample");
	property p_trig; trig |=> FREEZE; endproperty
	a_trig: assert property (p_trig) else $error("no freeze after trigger");
	property p_ever; cfg_q[4:2] == 3'h7 && FREEZE && !WR |=> FREEZE; endproperty
	a_ever: assert property (p_ever) else $error("frozen levels released");
	property p_hold; $fell(FREEZE) |-> int'(fcnt_q) >= hold_len(cfg_q[4:2]); endproperty
	a_hold: assert property (p_hold) else $error("freeze ended early");
	property p_tick;
		FILTER_CLK_TICK |-> gap_q == 16'h0000 ||
			int'(gap_q) == cs_freeze_pkg::BASE_DIV * (int'(filt_q[2:0]) + 1);
	endproperty
	a_tick: assert property (p_tick) else $error("filter tick period wrong");
	property p_rdat; !RD |=> RDATA == 8'h00; endproperty
	a_rdat: assert property (p_rdat) else $error("read data outside read");
endmodule
bind cs_freeze cs_freeze_chk chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FILT_VALID(FILT_VALID),
	.FREQ_SWITCH(FREQ_SWITCH), .LOCK_LOST(LOCK_LOST), .RX_POWER_UP(RX_POWER_UP),
	.LOCK_PIN(LOCK_PIN), .CARRIER_SENSE(CARRIER_SENSE), .FREEZE(FREEZE),
	.FILTER_CLK_TICK(FILTER_CLK_TICK));

// *** verification/rx_source.sv ***
// Receive path stand-in: filter samples and converter ticks
// Assumes the block's 200 MHz clock
`timescale 1ns/1ps
module rx_source (
	// Clock
	input  wire logic  clk,
	// Receive path
	output logic       filt_valid = 1'b0,
	output logic [7:0] magnitude  = 8'h00,
	output logic       adc_tick   = 1'b0
);
	logic [2:0] div_q = 3'h0;
	// Converter period of 8 clocks keeps the extra holds short
	always @(posedge clk) begin
		div_q    <= div_q + 3'h1;
		adc_tick <= div_q == 3'h7;
	end
	// Two equal samples form one average at the lowest setting
	task automatic send(input logic [7:0] m);
		@(posedge clk);
		filt_valid <= 1'b1;
		magnitude  <= m;
		repeat (2) @(posedge clk);
		filt_valid <= 1'b0;
		magnitude  <= ~m;
	endtask
endmodule

// *** verification/cs_freeze_tb.sv ***
// Bench for cs_freeze: register tasks, sample runs, freeze timing
// Assumes rx_source drives the receive path and the checker is bound
`timescale 1ns/1ps
module cs_freeze_tb;
	logic       REF_CLK, RST_N, WR, RD, FREQ_SWITCH, LOCK_LOST, RX_POWER_UP;
	logic       FILT_VALID, ADC_TICK, LOCK_PIN, CARRIER_SENSE, FREEZE, FILTER_CLK_TICK, IRQ;
	logic [3:0] ADDR;
	logic [7:0] WDATA, RDATA, MAGNITUDE, THRESHOLD;
	int         fail_count, n_checks;
	cs_freeze uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .FILT_VALID(FILT_VALID), .MAGNITUDE(MAGNITUDE),
		.THRESHOLD(THRESHOLD), .ADC_TICK(ADC_TICK), .FREQ_SWITCH(FREQ_SWITCH),
		.LOCK_LOST(LOCK_LOST), .RX_POWER_UP(RX_POWER_UP), .LOCK_PIN(LOCK_PIN),
		.CARRIER_SENSE(CARRIER_SENSE), .FREEZE(FREEZE), .FILTER_CLK_TICK(FILTER_CLK_TICK),
		.IRQ(IRQ));
	rx_source src (.clk(REF_CLK), .filt_valid(FILT_VALID), .magnitude(MAGNITUDE),
		.adc_tick(ADC_TICK));
	initial begin
		REF_CLK = 1'b0;
		forever #2.5 REF_CLK = ~REF_CLK;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge REF_CLK);
		{WR, ADDR, WDATA} <= {1'b1, a, v};
		@(posedge REF_CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge REF_CLK);
		{RD, ADDR} <= {1'b1, a};
		@(posedge REF_CLK);
		RD <= 1'b0;
		#1 chk("rdata", RDATA, exp);
	endtask
	// One average, then an edge to compare and one to update
	task automatic cs(input logic [7:0] m, input logic exp);
		src.send(m);
		repeat (2) @(posedge REF_CLK);
		#1 chk("carrier", CARRIER_SENSE, exp);
		chk("lock", LOCK_PIN, exp);
	endtask
	// Filter tick spacing; the first tick after a divisor write may be out of phase
	task automatic tick_gap(input int exp);
		int t;
		t = 0;
		#1;
		while (FILTER_CLK_TICK !== 1'b1 && t < 2000) begin
			@(posedge REF_CLK);
			#1 t++;
		end
		t = 0;
		do begin
			@(posedge REF_CLK);
			#1 t++;
		end while (FILTER_CLK_TICK !== 1'b1 && t < 2000);
		chk("tick gap", 8'(t == exp), 8'h01);
	endtask
	task automatic pulse(input int k);
		@(posedge REF_CLK);
		{RX_POWER_UP, LOCK_LOST, FREQ_SWITCH} <= 3'h1 << k;
		@(posedge REF_CLK);
		{RX_POWER_UP, LOCK_LOST, FREQ_SWITCH} <= 3'h0;
		#1 chk("freeze on", FREEZE, 1'b1);
	endtask
	// Tick phase is free running, so the length is only known to a window
	task automatic frz(input int k, input logic [2:0] h, input logic [1:0] x);
		int f, d;
		f = (h < 3'h5) ? 16 + 4 * int'(h) : 48 - 8 * int'(h == 3'h5);
		d = 0;
		wr(cs_freeze_pkg::ADDR_CFG, {3'h0, h, x});
		pulse(k);
		while (FREEZE === 1'b1 && d < 40000) begin
			@(posedge REF_CLK);
			#1 d++;
		end
		if (d >= 40000) begin
			fail_count++;
			end_of_test();
		end
		d = d - ((f - 1) * cs_freeze_pkg::BASE_DIV + ((16 << x) - 1) * 8);
		chk("freeze len", 8'(d >= 0 && d <= cs_freeze_pkg::BASE_DIV + 12), 8'h01);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		{RST_N, WR, RD, FREQ_SWITCH, LOCK_LOST, RX_POWER_UP} = 6'h00;
		{ADDR, WDATA, THRESHOLD} = {4'h0, 8'h00, 8'h40};
		fail_count = 0;
		n_checks = 0;
		repeat (16) @(posedge REF_CLK);
		RST_N <= 1'b1;
		rd(cs_freeze_pkg::ADDR_CFG, {2'h1, 1'h1, 3'h1, 2'h1});
		rd(4'hf, 8'h00);
		wr(cs_freeze_pkg::ADDR_FILT, 8'h00);
		for (int n = 0; n < 4; n++) begin
			wr(cs_freeze_pkg::ADDR_CFG, {n[1:0], 6'h00});
			cs(8'h3f, 1'b0);
			repeat (n) cs(8'h40, 1'b0);
			cs(8'h40, 1'b1);
			cs(8'h3f, 1'b0);
		end
		wr(cs_freeze_pkg::ADDR_CFG, {2'h3, 1'h1, 5'h00});
		repeat (3) cs(8'h40, 1'b0);
		cs(8'h3f, 1'b0);
		repeat (3) cs(8'h40, 1'b0);
		cs(8'h40, 1'b1);
		cs(8'h3f, 1'b1);
		cs(8'h40, 1'b1);
		cs(8'h3f, 1'b1);
		cs(8'h3f, 1'b0);
		rd(cs_freeze_pkg::ADDR_IRQ_ST, 8'h03);
		chk("irq masked", IRQ, 1'b0);
		wr(cs_freeze_pkg::ADDR_IRQ_EN, 8'h07);
		@(posedge REF_CLK);
		#1 chk("irq on", IRQ, 1'b1);
		wr(cs_freeze_pkg::ADDR_IRQ_CLR, 8'h03);
		@(posedge REF_CLK);
		#1 chk("irq off", IRQ, 1'b0);
		rd(cs_freeze_pkg::ADDR_IRQ_ST, 8'h00);
		for (int k = 0; k < 4; k++) frz(k % 3, 3'(k), 2'(k));
		chk("irq done", IRQ, 1'b1);
		rd(cs_freeze_pkg::ADDR_IRQ_ST, 8'h04);
		wr(cs_freeze_pkg::ADDR_CFG, 8'h1c);
		pulse(0);
		repeat (33000) @(posedge REF_CLK);
		#1 chk("frozen", FREEZE, 1'b1);
		rd(cs_freeze_pkg::ADDR_STATUS, 8'h02);
		wr(cs_freeze_pkg::ADDR_CFG, 8'h00);
		repeat (3) @(posedge REF_CLK);
		#1 chk("thawed", FREEZE, 1'b0);
		wr(cs_freeze_pkg::ADDR_FILT, 8'h31);
		rd(cs_freeze_pkg::ADDR_FILT, 8'h31);
		tick_gap(2 * cs_freeze_pkg::BASE_DIV);
		// Sixteen-sample window: the sum only reaches the threshold after a shift by four
		repeat (7) src.send(8'h40);
		cs(8'h40, 1'b1);
		rd(cs_freeze_pkg::ADDR_STATUS, 8'h01);
		// Four-sample window: a two-sample average would drop carrier sense here
		wr(cs_freeze_pkg::ADDR_FILT, 8'h11);
		src.send(8'h7f);
		cs(8'h02, 1'b1);
		src.send(8'h7e);
		cs(8'h00, 1'b0);
		rd(cs_freeze_pkg::ADDR_IRQ_EN, 8'h07);
		end_of_test();
	end
endmodule
